//--- hw/profile_cmd_pkg.sv
// Shared constants, types and selector decoding for the protocol profile command handler
package profile_cmd_pkg;

	// ----------------------------------------------------------------
	// Command codes and selector ranges
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_LOAD_PROFILE  = 8'h11;   // Copy stored profiles to working set
	localparam logic [7:0] CMD_STORE_PROFILE = 8'h12;   // Rewrite stored profile registers
	localparam logic [7:0] TX_SEL_MAX        = 8'h1c;   // Highest transmitter selector
	localparam logic [7:0] RX_SEL_MIN        = 8'h80;   // Lowest receiver selector
	localparam logic [7:0] RX_SEL_MAX        = 8'h9c;   // Highest receiver selector
	localparam logic [7:0] SEL_KEEP          = 8'hff;   // Leave this direction unchanged

	// ----------------------------------------------------------------
	// Payload geometry
	// ----------------------------------------------------------------
	localparam logic [7:0] LOAD_PARAM_BYTES  = 8'h02;   // Transmitter byte then receiver byte
	localparam logic [5:0] ELEM_MAX          = 6'h2a;   // At most 42 update elements
	localparam logic [2:0] ELEM_LAST_POS     = 3'h5;    // Six bytes per element, positions 0..5
	localparam logic [2:0] POS_SEL           = 3'h0;    // Element byte: profile selector
	localparam logic [2:0] POS_ADDR          = 3'h1;    // Element byte: register address

	// ----------------------------------------------------------------
	// Stored profile array layout
	// ----------------------------------------------------------------
	localparam logic [3:0] PROFILE_REGS      = 4'h8;    // Registers held by every profile
	localparam logic [5:0] PROFILES_PER_DIR  = 6'h1d;   // 29 profiles per direction
	localparam int         STORE_DEPTH       = 464;     // 58 profiles of 8 words
	localparam int         STORE_AW          = 9;       // Word address width of the store

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		proto_none,
		proto_type_a,
		proto_type_b,
		proto_jis_6319,
		proto_active_initiator,
		proto_vicinity,
		proto_epc_mode3,
		proto_card_emulation_side,
		proto_passive_target,
		proto_active_target,
		proto_all_rate_general_profile
	} proto_e;

	typedef enum logic [3:0] {
		rate_none,
		rate_26,
		rate_53,
		rate_106,
		rate_212,
		rate_424,
		rate_848,
		rate_tari_18_88,
		rate_tari_9_44,
		rate_all
	} rate_e;

	typedef enum logic [2:0] {
		exc_none,
		exc_tx_sel,
		exc_rx_sel,
		exc_length,
		exc_elem_sel,
		exc_elem_addr
	} exc_e;

	// One byte of a host command frame
	typedef struct packed {
		logic       valid;
		logic       first;
		logic       last;
		logic [7:0] data;
	} host_byte_s;

	// One write into the working configuration registers
	typedef struct packed {
		logic        valid;
		logic        is_rx;
		logic [7:0]  addr;
		logic [31:0] data;
	} cfg_write_s;

	// Decoded protocol and bit rate of a loaded profile
	typedef struct packed {
		proto_e proto;
		rate_e  rate;
	} mode_s;

	// Four step rate ladder used by several families
	function automatic rate_e step_rate(input logic [1:0] k);
		unique case (k)
			2'h0: step_rate = rate_106;
			2'h1: step_rate = rate_212;
			2'h2: step_rate = rate_424;
			2'h3: step_rate = rate_848;
		endcase
	endfunction

	// Selector byte to protocol and rate; codes are checked before use
	function automatic mode_s decode_sel(input logic [7:0] sel);
		logic  rx;
		mode_s m;
		rx = sel[7];
		m  = '{proto_none, rate_none};
		case (sel[6:0])
			7'h00, 7'h01, 7'h02, 7'h03: m = '{proto_type_a, step_rate(sel[1:0])};
			7'h04, 7'h05, 7'h06, 7'h07: m = '{proto_type_b, step_rate(sel[1:0])};
			7'h08: m = '{proto_jis_6319, rate_212};
			7'h09: m = '{proto_jis_6319, rate_424};
			7'h0a: m = '{proto_active_initiator, rate_106};
			7'h0b: m = '{proto_active_initiator, rate_212};
			7'h0c: m = '{proto_active_initiator, rate_424};
			7'h0d: m = '{proto_vicinity, rate_26};
			7'h0e: m = '{proto_vicinity, rx ? rate_53 : rate_26};
			7'h0f: m = '{proto_epc_mode3, rx ? rate_106 : rate_tari_18_88};
			7'h10: m = '{proto_epc_mode3, rx ? rate_212 : rate_tari_9_44};
			7'h11: m = '{proto_epc_mode3, rx ? rate_212 : rate_tari_18_88};
			7'h12: m = '{proto_epc_mode3, rx ? rate_424 : rate_tari_9_44};
			7'h13: m = '{rx ? proto_card_emulation_side : proto_epc_mode3, rate_106};
			7'h14: m = '{proto_card_emulation_side, rate_212};
			7'h15: m = '{proto_card_emulation_side, rate_424};
			7'h16: m = '{proto_card_emulation_side, rate_848};
			7'h17: m = '{proto_passive_target, rate_212};
			7'h18: m = '{proto_passive_target, rate_424};
			7'h19, 7'h1a, 7'h1b:
				m = '{rx ? proto_type_a : proto_active_target, step_rate(2'(sel[1:0] - 2'h1))};
			7'h1c: m = '{proto_all_rate_general_profile, rate_all};
			default: m = '{proto_none, rate_none};
		endcase
		decode_sel = m;
	endfunction

endpackage

//--- hw/profile_store.sv
// Non-volatile stored profile array with one read and one write port
`timescale 1ns/1ps
`default_nettype none

module profile_store
(
	input  wire logic                                   clk,
	input  wire logic                                   rd_en,
	input  wire logic [profile_cmd_pkg::STORE_AW-1:0]   rd_addr,
	output var  logic [31:0]                            rd_data,
	input  wire logic                                   wr_en,
	input  wire logic [profile_cmd_pkg::STORE_AW-1:0]   wr_addr,
	input  wire logic [31:0]                            wr_data
);
	import profile_cmd_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// No reset: contents survive reset like the non-volatile area they model
	logic [31:0] mem [STORE_DEPTH];

	// Write port, only driven by the update command
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Registered read, one cycle latency
	always_ff @(posedge clk)
	begin
		if (rd_en)
			rd_data <= mem[rd_addr];
	end

endmodule // profile_store

`default_nettype wire

//--- hw/profile_cmd.sv
// Load and update handling for stored transmitter and receiver protocol profiles
//
// Functional notes
// - Transmitter selector accepted only 0x00 to 0x1C.
// - Transmitter selector 0xFF keeps transmitter configuration.
// - Receiver selector accepted only 0x80 to 0x9C.
// - Receiver selector 0xFF keeps receiver configuration.
// - Mismatched rates load silently, no error.
// - Codes 00-07 / 80-87 decode type A/B rates.
// - Codes 0F-12 / 8F-92 decode Manchester profiles.
// - Codes 19-1B active target; 99-9B type A.
// - Command 0x12 rewrites stored profile registers.
// - Update touches only locations named by elements.
// - Update carries 1 to 42 elements only.
// - Element is selector, address, four value bytes.
// - Multi-byte values arrive least significant byte first.
// - Element selector must be 0x00-0x1C or 0x80-0x9C.
// - Element address must exist inside its profile.
// - Any update parameter violation raises an exception.
// - Command 0x11 copies stored profiles to working registers.
// - Stored profiles change only through the update command.
`timescale 1ns/1ps
`default_nettype none

module profile_cmd
(
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire profile_cmd_pkg::host_byte_s   host_in,
	output var  logic                          busy,
	output var  profile_cmd_pkg::cfg_write_s   cfg_wr,
	output var  profile_cmd_pkg::mode_s        tx_mode,
	output var  profile_cmd_pkg::mode_s        rx_mode,
	output var  logic                          done,
	output var  logic                          exception,
	output var  profile_cmd_pkg::exc_e         exc_code
);
	import profile_cmd_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {st_idle, st_collect, st_check, st_copy, st_commit, st_finish} state_e;

	state_e          state_ff;          // Command sequencer
	logic [7:0]      cmd_ff;            // Command code of current frame
	logic [7:0]      tx_sel_ff;         // Transmitter selector byte
	logic [7:0]      rx_sel_ff;         // Receiver selector byte
	logic [7:0]      par_cnt_ff;        // Parameter bytes seen by load command
	logic [2:0]      pos_ff;            // Byte position inside update element
	logic [5:0]      elem_ff;           // Complete or started update elements
	logic            err_ff;            // A parameter check failed
	exc_e            err_code_ff;       // First failing check
	logic            copy_rx_ff;        // Copy phase: receiver profile
	logic [3:0]      cp_idx_ff;         // Register index being read
	logic            rd_pend_ff;        // Read issued last cycle
	logic            rd_rx_ff;          // Direction of the pending read
	logic [7:0]      rd_idx_ff;         // Register index of the pending read
	logic [5:0]      wr_idx_ff;         // Element being committed
	logic            busy_ff;
	cfg_write_s      cfg_wr_ff;
	mode_s           tx_mode_ff;
	mode_s           rx_mode_ff;
	logic            done_ff;
	logic            exception_ff;
	exc_e            exc_code_ff;

	// Update elements held until the whole frame has been checked
	logic [7:0]      sel_buf [ELEM_MAX];
	logic [2:0]      addr_buf [ELEM_MAX];
	logic [31:0]     val_buf [ELEM_MAX];

	logic            byte_in;           // Parameter byte accepted this cycle
	logic            rd_en;             // Store read strobe
	logic [STORE_AW-1:0] rd_addr;
	logic [31:0]     rd_data;
	logic            wr_en;             // Store write strobe
	logic [STORE_AW-1:0] wr_addr;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic tx_ok(input logic [7:0] s);
		tx_ok = (s <= TX_SEL_MAX);      // Lower bound is zero
	endfunction

	function automatic logic rx_ok(input logic [7:0] s);
		rx_ok = (s >= RX_SEL_MIN) && (s <= RX_SEL_MAX);
	endfunction

	// First word of a profile in the store; receiver profiles follow transmitter ones
	function automatic logic [STORE_AW-1:0] prof_base(input logic [7:0] s);
		logic [5:0] idx;
		idx = s[7] ? 6'(s[4:0]) + PROFILES_PER_DIR : s[5:0];
		prof_base = {idx, 3'h0};
	endfunction

	assign byte_in = host_in.valid && !host_in.first && (state_ff == st_collect);

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			state_ff <= st_idle;
		else
		begin
			unique case (state_ff)
				// A frame start with one of our codes opens a command
				st_idle, st_collect:
				begin
					if (host_in.valid && host_in.first)
					begin
						if (host_in.data == CMD_LOAD_PROFILE || host_in.data == CMD_STORE_PROFILE)
							state_ff <= host_in.last ? st_check : st_collect;
						else
							state_ff <= st_idle;   // Other commands are not ours
					end
					else if (byte_in && host_in.last)
						state_ff <= st_check;
				end
				// Everything is checked before any state changes
				st_check:
				begin
					if (cmd_ff == CMD_LOAD_PROFILE)
					begin
						if (err_ff || par_cnt_ff != LOAD_PARAM_BYTES)
							state_ff <= st_finish;
						else if (tx_sel_ff == SEL_KEEP && rx_sel_ff == SEL_KEEP)
							state_ff <= st_finish;
						else
							state_ff <= st_copy;
					end
					else if (err_ff || elem_ff == 6'h0 || pos_ff != POS_SEL)
						state_ff <= st_finish;
					else
						state_ff <= st_commit;
				end
				// Leave after the last read of the last direction
				st_copy:
				begin
					if (cp_idx_ff == PROFILE_REGS && (copy_rx_ff || rx_sel_ff == SEL_KEEP))
						state_ff <= st_finish;
				end
				st_commit:
				begin
					if (wr_idx_ff == 6'(elem_ff - 6'h1))
						state_ff <= st_finish;
				end
				st_finish:
					state_ff <= st_idle;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Frame capture and parameter checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cmd_ff      <= 8'h00;
			tx_sel_ff   <= SEL_KEEP;
			rx_sel_ff   <= SEL_KEEP;
			par_cnt_ff  <= 8'h00;
			pos_ff      <= POS_SEL;
			elem_ff     <= 6'h0;
			err_ff      <= 1'b0;
			err_code_ff <= exc_none;
		end
		else if ((state_ff == st_idle || state_ff == st_collect) && host_in.valid && host_in.first)
		begin
			// New frame clears all capture state
			cmd_ff      <= host_in.data;
			tx_sel_ff   <= SEL_KEEP;
			rx_sel_ff   <= SEL_KEEP;
			par_cnt_ff  <= 8'h00;
			pos_ff      <= POS_SEL;
			elem_ff     <= 6'h0;
			err_ff      <= 1'b0;
			err_code_ff <= exc_none;
		end
		else if (byte_in)
		begin
			// Saturate so long frames cannot wrap back to a legal count
			if (par_cnt_ff != 8'hff)
				par_cnt_ff <= par_cnt_ff + 8'h01;
			if (cmd_ff == CMD_LOAD_PROFILE)
			begin
				if (par_cnt_ff == 8'h00)
				begin
					tx_sel_ff <= host_in.data;
					if (!tx_ok(host_in.data) && host_in.data != SEL_KEEP && !err_ff)
					begin
						err_ff      <= 1'b1;
						err_code_ff <= exc_tx_sel;
					end
				end
				else if (par_cnt_ff == 8'h01)
				begin
					rx_sel_ff <= host_in.data;
					if (!rx_ok(host_in.data) && host_in.data != SEL_KEEP && !err_ff)
					begin
						err_ff      <= 1'b1;
						err_code_ff <= exc_rx_sel;
					end
				end
			end
			else
			begin
				// Six byte elements, wrap position after the last value byte
				pos_ff <= (pos_ff == ELEM_LAST_POS) ? POS_SEL : pos_ff + 3'h1;
				if (pos_ff == POS_SEL)
				begin
					if (elem_ff == ELEM_MAX)
					begin
						if (!err_ff)
						begin
							err_ff      <= 1'b1;
							err_code_ff <= exc_length;
						end
					end
					else
					begin
						elem_ff <= elem_ff + 6'h1;
						if (!tx_ok(host_in.data) && !rx_ok(host_in.data) && !err_ff)
						begin
							err_ff      <= 1'b1;
							err_code_ff <= exc_elem_sel;
						end
					end
				end
				else if (pos_ff == POS_ADDR && host_in.data >= 8'(PROFILE_REGS) && !err_ff)
				begin
					err_ff      <= 1'b1;
					err_code_ff <= exc_elem_addr;
				end
			end
		end
		else if (state_ff == st_check && cmd_ff == CMD_LOAD_PROFILE && !err_ff
			&& par_cnt_ff != LOAD_PARAM_BYTES)
			err_code_ff <= exc_length;
		else if (state_ff == st_check && cmd_ff == CMD_STORE_PROFILE && !err_ff
			&& (elem_ff == 6'h0 || pos_ff != POS_SEL))
			err_code_ff <= exc_length;
	end

	// Element buffer; nothing reaches the store until the frame passes
	always_ff @(posedge clk)
	begin
		if (byte_in && cmd_ff == CMD_STORE_PROFILE && elem_ff <= ELEM_MAX)
		begin
			unique case (pos_ff)
				3'h0:
				begin
					if (elem_ff != ELEM_MAX)
						sel_buf[elem_ff] <= host_in.data;
				end
				3'h1: addr_buf[6'(elem_ff - 6'h1)] <= host_in.data[2:0];
				3'h2: val_buf[6'(elem_ff - 6'h1)][7:0]   <= host_in.data;
				3'h3: val_buf[6'(elem_ff - 6'h1)][15:8]  <= host_in.data;
				3'h4: val_buf[6'(elem_ff - 6'h1)][23:16] <= host_in.data;
				3'h5: val_buf[6'(elem_ff - 6'h1)][31:24] <= host_in.data;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Profile copy into working registers
	// ----------------------------------------------------------------
	assign rd_en   = (state_ff == st_copy) && (cp_idx_ff != PROFILE_REGS);
	assign rd_addr = prof_base(copy_rx_ff ? rx_sel_ff : tx_sel_ff) + STORE_AW'(cp_idx_ff);

	// Read index walk, transmitter first, then receiver
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			copy_rx_ff <= 1'b0;
			cp_idx_ff  <= 4'h0;
		end
		else if (state_ff == st_check)
		begin
			copy_rx_ff <= (tx_sel_ff == SEL_KEEP);
			cp_idx_ff  <= 4'h0;
		end
		else if (rd_en)
			cp_idx_ff <= cp_idx_ff + 4'h1;
		else if (state_ff == st_copy && !copy_rx_ff && rx_sel_ff != SEL_KEEP)
		begin
			copy_rx_ff <= 1'b1;
			cp_idx_ff  <= 4'h0;
		end
	end

	// Read data lands one cycle after the strobe and is forwarded as a write
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_pend_ff <= 1'b0;
			rd_rx_ff   <= 1'b0;
			rd_idx_ff  <= 8'h00;
			cfg_wr_ff  <= '0;
		end
		else
		begin
			rd_pend_ff <= rd_en;
			rd_rx_ff   <= copy_rx_ff;
			rd_idx_ff  <= 8'(cp_idx_ff);
			cfg_wr_ff  <= '{rd_pend_ff, rd_rx_ff, rd_idx_ff, rd_data};
		end
	end

	// Decoded modes follow each completed direction; rate mismatch is allowed
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_mode_ff <= '{proto_none, rate_none};
			rx_mode_ff <= '{proto_none, rate_none};
		end
		else if (state_ff == st_copy && cp_idx_ff == PROFILE_REGS)
		begin
			if (copy_rx_ff)
				rx_mode_ff <= decode_sel(rx_sel_ff);
			else
				tx_mode_ff <= decode_sel(tx_sel_ff);
		end
	end

	// ----------------------------------------------------------------
	// Commit of checked update elements
	// ----------------------------------------------------------------
	// The only write path into the store
	assign wr_en   = (state_ff == st_commit);
	assign wr_addr = prof_base(sel_buf[wr_idx_ff]) + STORE_AW'(addr_buf[wr_idx_ff]);

	always_ff @(posedge clk)
	begin
		if (rst || state_ff != st_commit)
			wr_idx_ff <= 6'h0;
		else
			wr_idx_ff <= wr_idx_ff + 6'h1;
	end

	profile_store u_store
	(
		.clk     (clk),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (val_buf[wr_idx_ff])
	);

	// ----------------------------------------------------------------
	// Completion and exception reporting
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			busy_ff      <= 1'b0;
			done_ff      <= 1'b0;
			exception_ff <= 1'b0;
			exc_code_ff  <= exc_none;
		end
		else
		begin
			busy_ff      <= (state_ff == st_check || state_ff == st_copy || state_ff == st_commit);
			done_ff      <= (state_ff == st_finish);
			exception_ff <= (state_ff == st_finish) && (err_code_ff != exc_none);
			if (state_ff == st_finish)
				exc_code_ff <= err_code_ff;
		end
	end

	assign busy      = busy_ff;
	assign cfg_wr    = cfg_wr_ff;
	assign tx_mode   = tx_mode_ff;
	assign rx_mode   = rx_mode_ff;
	assign done      = done_ff;
	assign exception = exception_ff;
	assign exc_code  = exc_code_ff;

endmodule // profile_cmd

`default_nettype wire

//--- verification/profile_cmd_checker.sv
// Assertion checker for the protocol profile command handler
`timescale 1ns/1ps
`default_nettype none

module profile_cmd_checker
(
	input wire logic                        clk,
	input wire logic                        rst,
	input wire profile_cmd_pkg::cfg_write_s cfg_wr,
	input wire profile_cmd_pkg::mode_s      tx_mode,
	input wire profile_cmd_pkg::mode_s      rx_mode,
	input wire logic                        done,
	input wire logic                        exception,
	input wire profile_cmd_pkg::exc_e       exc_code
);
	import profile_cmd_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ----------
	// Copy sequence
	// ----------
	// First word of a copy into the working set
	sequence s_first_wr;
		cfg_wr.valid && cfg_wr.addr == 8'h00;
	endsequence
	// Clean end pulse of the command
	sequence s_clean_end;
		done && !exception;
	endsequence
	// One idle cycle, then the receiver copy opens
	sequence s_rx_next;
		!cfg_wr.valid && !done ##1 cfg_wr.valid && cfg_wr.is_rx && cfg_wr.addr == 8'h00;
	endsequence
	// Seven further words, then the end pulse or the receiver copy
	sequence s_rest_wr;
		cfg_wr.valid [*7] ##1 (s_clean_end or s_rx_next);
	endsequence

	AST_COPY_BURST: assert property (s_first_wr |=> s_rest_wr)
		else $error("copy is not eight words then done");
	AST_LAST_WR: assert property (cfg_wr.valid && cfg_wr.is_rx && cfg_wr.addr == 8'h07 |=> s_clean_end)
		else $error("copy end without clean done");
	AST_WR_ADDR: assert property (cfg_wr.valid |-> cfg_wr.addr < 8'h08)
		else $error("copy index outside profile");

	// ----------
	// End of command
	// ----------
	AST_EXC_DONE: assert property (exception |-> done)
		else $error("exception without done");
	AST_DONE_PULSE: assert property (done |=> !done)
		else $error("done longer than one cycle");
	AST_EXC_CODE: assert property (done |-> exception == (exc_code != exc_none))
		else $error("cause disagrees with exception");
	// A failed check is found before any copy starts
	AST_FAIL_QUIET: assert property (exception |-> !$past(cfg_wr.valid) && !$past(cfg_wr.valid, 2))
		else $error("working write before exception");
	// A mode moves only with the last word of its own direction
	AST_MODE_END: assert property ($changed(tx_mode) |-> cfg_wr.valid && !cfg_wr.is_rx && cfg_wr.addr == 8'h07)
		else $error("transmitter mode changed outside its copy end");
	AST_RX_MODE_END: assert property ($changed(rx_mode) |-> cfg_wr.valid && cfg_wr.is_rx && cfg_wr.addr == 8'h07)
		else $error("receiver mode changed outside its copy end");
endmodule // profile_cmd_checker

bind profile_cmd profile_cmd_checker chk (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .tx_mode(tx_mode),
	.rx_mode(rx_mode), .done(done), .exception(exception), .exc_code(exc_code));

`default_nettype wire

//--- verification/host_model.sv
// Host side model that sends command frames one byte a cycle
`timescale 1ns/1ps
`default_nettype none

module host_model
(
	input  wire logic                        clk,
	output var  profile_cmd_pkg::host_byte_s host_in
);
	import profile_cmd_pkg::*;

	logic [7:0] q[$];	// Frame bytes, command code first

	initial host_in = '{1'b0, 1'b0, 1'b0, 8'h00};

	// Send the whole queued frame; bytes go out exactly as queued, cut elements included
	task automatic send();
		int n;
		n = q.size();
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			#1;
			host_in = '{1'b1, i == 0, i == n - 1, q[i]};
		end
		@(posedge clk);
		#1;
		// Released line shows the inverse, never a stale byte
		host_in = '{1'b0, 1'b0, 1'b0, ~host_in.data};
		q.delete();
	endtask
endmodule // host_model

`default_nettype wire

//--- verification/profile_cmd_tb.sv
// Self-checking bench for the protocol profile command handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
	$display("wrong value %s exp %h got %h", nm, ex, got); end end

module profile_cmd_tb;
	import profile_cmd_pkg::*;

	logic        clk;
	logic        rst;
	host_byte_s  host_in;
	logic        busy;
	cfg_write_s  cfg_wr;
	mode_s       tx_mode;
	mode_s       rx_mode;
	logic        done;
	logic        exception;
	exc_e        exc_code;
	int          n_errors;
	int          total_checks;
	logic [31:0] wd[2][8];	// Last copied word per direction and index
	exc_e        got_exc;	// Cause seen at the end pulse
	logic        got_x;	// Exception seen at the end pulse

	host_model host (.clk(clk), .host_in(host_in));
	profile_cmd dut (.clk(clk), .rst(rst), .host_in(host_in), .busy(busy), .cfg_wr(cfg_wr),
		.tx_mode(tx_mode), .rx_mode(rx_mode), .done(done), .exception(exception),
		.exc_code(exc_code));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	// Record every working-register write
	always @(posedge clk)
		if (cfg_wr.valid === 1'b1)
			wd[cfg_wr.is_rx][cfg_wr.addr[2:0]] <= cfg_wr.data;

	// ----------
	// Helpers
	// ----------
	function automatic logic [31:0] v(input logic [7:0] s, input logic [7:0] a);
		return {a ^ 8'h3c, s, a, 8'hc3};
	endfunction

	task automatic results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Send the frame and wait, bounded, for the end pulse
	task automatic run();
		int i;
		logic seen;	// Busy shown while the command ran
		seen = 1'b0;
		host.send();
		for (i = 0; i < 500 && done !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
			seen = seen | (busy === 1'b1);
		end
		if (i == 500)
		begin
			n_errors++;
			$display("wrong value done exp 1 got 0");
			results();
		end
		got_exc = exc_code;
		got_x = exception;
		`CHK("busy seen", 1'b1, seen)
		`CHK("busy at end", 1'b0, busy)
	endtask

	// One element, value least significant byte first
	task automatic elem(input logic [7:0] s, input logic [7:0] a, input logic [31:0] d);
		host.q.push_back(s);
		host.q.push_back(a);
		for (int b = 0; b < 4; b++)
			host.q.push_back(d[8*b +: 8]);
	endtask

	task automatic ld(input logic [7:0] t, input logic [7:0] r, input exc_e ex);
		host.q = '{CMD_LOAD_PROFILE, t, r};
		run();
		`CHK("exc_code", ex, got_exc)
		`CHK("exception", ex != exc_none, got_x)
	endtask

	task automatic dec(input logic [7:0] t, input logic [7:0] r, input mode_s mt, input mode_s mr);
		ld(t, r, exc_none);
		`CHK("tx_mode", mt, tx_mode)
		`CHK("rx_mode", mr, rx_mode)
	endtask

	// ----------
	// Scenarios
	// ----------
	// Fill two profiles, then copy them to the working set
	task automatic t_store_load();
		host.q.push_back(CMD_STORE_PROFILE);
		for (int a = 0; a < 8; a++)
		begin
			elem(8'h00, 8'(a), v(8'h00, 8'(a)));
			elem(8'h80, 8'(a), v(8'h80, 8'(a)));
		end
		run();
		`CHK("store exc", exc_none, got_exc)
		dec(8'h00, 8'h80, '{proto_type_a, rate_106}, '{proto_type_a, rate_106});
		for (int a = 0; a < 8; a++)
		begin
			`CHK("tx word", v(8'h00, 8'(a)), wd[0][a])
			`CHK("rx word", v(8'h80, 8'(a)), wd[1][a])
		end
		$display("test store_load done");
	endtask

	// One location rewritten, then broken updates that must change nothing
	task automatic t_update();
		exc_e ec[5];
		ec = '{exc_elem_sel, exc_elem_addr, exc_length, exc_length, exc_length};
		host.q.push_back(CMD_STORE_PROFILE);
		elem(8'h00, 8'h03, 32'h0);
		elem(8'h00, 8'h03, 32'h89abcdef);
		run();
		for (int k = 0; k < 5; k++)
		begin
			host.q.push_back(CMD_STORE_PROFILE);
			if (k < 2)
				elem(8'h00, 8'h05, 32'h0);
			if (k == 0)
				elem(8'h1d, 8'h01, 32'h0);
			if (k == 1)
				elem(8'h00, 8'h08, 32'h0);
			for (int e = 0; e < 43 && k == 3; e++)
				elem(8'h00, 8'h06, 32'h0);
			if (k == 4)
				elem(8'h00, 8'h06, 32'h0);
			if (k == 4)
				void'(host.q.pop_back());
			run();
			`CHK("update exc", ec[k], got_exc)
		end
		ld(8'h00, 8'h80, exc_none);
		for (int a = 0; a < 8; a++)
		begin
			`CHK("tx word", a == 3 ? 32'h89abcdef : v(8'h00, 8'(a)), wd[0][a])
			`CHK("rx word", v(8'h80, 8'(a)), wd[1][a])
		end
		$display("test update done");
	endtask

	// Selector decoding, keep codes, bounds and refusals
	task automatic t_select();
		dec(8'h03, 8'h84, '{proto_type_a, rate_848}, '{proto_type_b, rate_106});
		dec(8'h07, 8'h83, '{proto_type_b, rate_848}, '{proto_type_a, rate_848});
		dec(8'h0f, 8'h8f, '{proto_epc_mode3, rate_tari_18_88}, '{proto_epc_mode3, rate_106});
		dec(8'h10, 8'h90, '{proto_epc_mode3, rate_tari_9_44}, '{proto_epc_mode3, rate_212});
		dec(8'h11, 8'h91, '{proto_epc_mode3, rate_tari_18_88}, '{proto_epc_mode3, rate_212});
		dec(8'h12, 8'h92, '{proto_epc_mode3, rate_tari_9_44}, '{proto_epc_mode3, rate_424});
		dec(8'h19, 8'h99, '{proto_active_target, rate_106}, '{proto_type_a, rate_106});
		dec(8'h1a, 8'h9a, '{proto_active_target, rate_212}, '{proto_type_a, rate_212});
		dec(8'h1b, 8'h9b, '{proto_active_target, rate_424}, '{proto_type_a, rate_424});
		dec(8'hff, 8'h81, '{proto_active_target, rate_424}, '{proto_type_a, rate_212});
		dec(8'h05, 8'hff, '{proto_type_b, rate_212}, '{proto_type_a, rate_212});
		ld(8'h1d, 8'h80, exc_tx_sel);
		ld(8'h80, 8'h80, exc_tx_sel);
		ld(8'h00, 8'h9d, exc_rx_sel);
		ld(8'h00, 8'h7f, exc_rx_sel);
		`CHK("tx_mode", mode_s'{proto_type_b, rate_212}, tx_mode)
		`CHK("rx_mode", mode_s'{proto_type_a, rate_212}, rx_mode)
		dec(8'h1c, 8'h9c, '{proto_all_rate_general_profile, rate_all},
			'{proto_all_rate_general_profile, rate_all});
		$display("test select done");
	endtask

	// ----------
	// Main sequence
	// ----------
	initial
	begin
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		t_store_load();
		t_update();
		t_select();
		results();
	end
endmodule // profile_cmd_tb

`default_nettype wire
